//--- inc/reader_irq_pkg.sv
// Notes on behaviour
// - Primary status bit 7 sets when a transmission completes.
// - Primary status bit 6 sets when a reception completes.
// - Bit 5 sets on FIFO below 6 bytes in transmit, above 18 in receive.
// - Primary bit 4 sets whenever any reception or transmission error source fires.
// - Bit 3 flags header bit one, or two bytes in FIFO with option.
// - Bit 1 sets when automatic acknowledge ends, success, timeout or error.
// - Both status registers read zero after reset and while chip enable is low.
// - A completed read of a status register clears what was read.
// - Secondary bit 7 sets on either edge of oscillator, PLL or field status.
// - Secondary bit 6 sets when a direct command finishes.
// - Secondary bit 2 flags CRC error; bit 1 short reception or protocol violation.
// - Secondary bit 0 flags preamble error or FIFO overflow in either direction.
// - Interrupt output is high while any enabled flag is set.
// - FIFO status bit 7 shows transmit active, bit 6 receive active.
// - FIFO status bit 5 sets when more than 24 bytes were loaded.
// - Five-bit unread byte count, reading 1Fh for an empty FIFO.
// - Flags always set on events; enables gate the interrupt output and the no-response abort.
// - With no-response interrupt disabled, the timer never aborts a reception.
// - With the option set, header flag becomes the second-byte flag.
package reader_irq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE_PRIMARY   = 8'h35;
  localparam logic [7:0] IDX_ENABLE_SECONDARY = 8'h36;
  localparam logic [7:0] IDX_STATUS_PRIMARY   = 8'h37;
  localparam logic [7:0] IDX_STATUS_SECONDARY = 8'h38;
  localparam logic [7:0] IDX_FIFO_STATUS      = 8'h39;
  localparam logic [7:0] IDX_RX_LENGTH_UPPER  = 8'h3a;

  // Reset values
  localparam logic [7:0] RST_ENABLE_PRIMARY   = 8'hf7;
  localparam logic [7:0] RST_ENABLE_SECONDARY = 8'h40;
  localparam logic [7:0] RST_STATUS           = 8'h00;
  localparam logic [7:0] RST_RX_LENGTH_UPPER  = 8'h00;

  // Primary status bit positions
  localparam int P_TX_DONE   = 7;
  localparam int P_RX_DONE   = 6;
  localparam int P_FIFO_LVL  = 5;
  localparam int P_ERROR     = 4;
  localparam int P_HEADER    = 3;
  localparam int P_AUTO_ACK  = 1;
  localparam int P_NO_RESP   = 0;
  localparam logic [7:0] PRIMARY_USED   = 8'hfb;

  // Secondary status bit positions
  localparam int S_ANALOG    = 7;
  localparam int S_CMD_DONE  = 6;
  localparam int S_CRC       = 2;
  localparam int S_LENGTH    = 1;
  localparam int S_PREAMBLE  = 0;
  localparam logic [7:0] SECONDARY_USED = 8'hc7;

  // FIFO status layout and rx length option bit
  localparam int F_TX_ACTIVE = 7;
  localparam int F_RX_ACTIVE = 6;
  localparam int F_OVERFLOW  = 5;
  localparam int RXL_SECOND_BYTE_BIT = 6;

  // FIFO thresholds in bytes
  localparam logic [5:0] TX_LOW_LEVEL    = 6'd6;
  localparam logic [5:0] RX_HIGH_LEVEL   = 6'd18;
  localparam logic [5:0] FIFO_CAPACITY   = 6'd24;
  localparam logic [5:0] SECOND_BYTE_LVL = 6'd2;
  localparam logic [4:0] EMPTY_READ_CODE = 5'h1f;

  // Event strobes from the reader core, one clock pulses
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic header_bit_one;
    logic auto_ack_done;
    logic no_response_timeout;
    logic cmd_done;
    logic crc_error;
    logic length_error;
    logic protocol_error;
    logic preamble_error;
  } reader_events_t;

  // FIFO side levels, same clock
  typedef struct packed {
    logic       tx_active;
    logic       rx_active;
    logic       push;
    logic [5:0] level;
  } fifo_view_t;

  // Asynchronous analog status pins
  typedef struct packed {
    logic osc_ok;
    logic pll_ok;
    logic field_present_good;
  } analog_status_t;

endpackage : reader_irq_pkg

//--- logic/reader_irq_status.sv
`timescale 1ns/1ps
module reader_irq_status (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           sys_rst,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Pins
  input  wire logic                           chip_enable,
  input  wire reader_irq_pkg::analog_status_t analog_pins,
  // Reader core
  input  wire reader_irq_pkg::reader_events_t events,
  input  wire reader_irq_pkg::fifo_view_t     fifo,
  // Outputs
  output logic                                irq,
  output logic                                abort_receive,
  output logic                                direct_fifo_second_byte_option
);
  import reader_irq_pkg::*;

  typedef struct packed {
    logic [7:0] enable_primary;
    logic [7:0] enable_secondary;
    logic [7:0] status_primary;
    logic [7:0] status_secondary;
    logic [7:0] rx_length_upper;
    logic       overflow;
    logic       fifo_cond;
    logic       second_cond;
    logic [1:0] chip_en_sync;
    logic [2:0] ana_meta;
    logic [2:0] ana_sync;
    logic [2:0] ana_last;
    logic [7:0] read_snap;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [7:0] word_index(input logic [11:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx >= IDX_ENABLE_PRIMARY) && (idx <= IDX_RX_LENGTH_UPPER);
  endfunction : mapped

  logic       setup;
  logic       access;
  logic [7:0] idx;
  logic       addr_ok;
  logic       chip_on;
  logic [4:0] unread;
  logic [7:0] fifo_status;
  logic [7:0] p_set;
  logic [7:0] s_set;
  logic       any_error;
  logic       ovf_event;
  logic       fifo_now;
  logic       second_now;
  logic       option;
  logic       clear_primary;
  logic       clear_secondary;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign idx     = word_index(paddr);
  assign addr_ok = mapped(idx) && (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign chip_on = s_q.chip_en_sync[1];
  assign option  = s_q.rx_length_upper[RXL_SECOND_BYTE_BIT];

  assign unread = (fifo.level == 6'd0) ? EMPTY_READ_CODE : fifo.level[4:0];

  always_comb begin
    fifo_status              = {3'b000, unread};
    fifo_status[F_TX_ACTIVE] = fifo.tx_active;
    fifo_status[F_RX_ACTIVE] = fifo.rx_active;
    fifo_status[F_OVERFLOW]  = s_q.overflow;
  end

  assign ovf_event = fifo.push && (fifo.level >= FIFO_CAPACITY);

  assign fifo_now = (fifo.tx_active && (fifo.level < TX_LOW_LEVEL)) ||
                    (fifo.rx_active && (fifo.level > RX_HIGH_LEVEL));

  assign second_now = option && fifo.rx_active && (fifo.level >= SECOND_BYTE_LVL);

  assign any_error = events.crc_error || events.length_error || events.protocol_error ||
                     events.preamble_error || ovf_event;

  // Set terms; flags ignore enables
  always_comb begin
    p_set = 8'h00;
    s_set = 8'h00;
    p_set[P_TX_DONE] = events.tx_done;
    p_set[P_RX_DONE] = events.rx_done;
    p_set[P_FIFO_LVL] = fifo_now && !s_q.fifo_cond;
    p_set[P_ERROR] = any_error;
    p_set[P_HEADER] = option ? (second_now && !s_q.second_cond) : events.header_bit_one;
    p_set[P_AUTO_ACK] = events.auto_ack_done;
    p_set[P_NO_RESP]  = events.no_response_timeout;
    s_set[S_ANALOG] = |(s_q.ana_sync ^ s_q.ana_last);
    s_set[S_CMD_DONE] = events.cmd_done;
    s_set[S_CRC]    = events.crc_error;
    s_set[S_LENGTH] = events.length_error || events.protocol_error;
    s_set[S_PREAMBLE] = events.preamble_error || ovf_event;
  end

  // Clear at end of read phase
  assign clear_primary   = access && !pwrite && addr_ok && (idx == IDX_STATUS_PRIMARY);
  assign clear_secondary = access && !pwrite && addr_ok && (idx == IDX_STATUS_SECONDARY);

  always_comb begin
    s_d = s_q;

    // Chip enable and analog pins pass two flops first
    s_d.chip_en_sync = {s_q.chip_en_sync[0], chip_enable};
    s_d.ana_meta     = {analog_pins.osc_ok, analog_pins.pll_ok, analog_pins.field_present_good};
    s_d.ana_sync     = s_q.ana_meta;
    s_d.ana_last     = s_q.ana_sync;

    s_d.fifo_cond   = fifo_now;
    s_d.second_cond = second_now;

    // Only bits shown to the host are cleared; set wins over clear
    s_d.status_primary = ((s_q.status_primary & ~(clear_primary ? s_q.read_snap : 8'h00)) | p_set)
                         & PRIMARY_USED;
    s_d.status_secondary = ((s_q.status_secondary & ~(clear_secondary ? s_q.read_snap : 8'h00)) | s_set)
                           & SECONDARY_USED;

    // Overflow stays until a new transfer starts
    if (ovf_event) begin
      s_d.overflow = 1'b1;
    end else if (fifo.push && fifo.level == 6'd0) begin
      s_d.overflow = 1'b0;
    end

    // Read data captured in setup so the clear matches what is returned
    if (setup) begin
      s_d.read_snap = 8'h00;
      s_d.rdata     = 32'h0000_0000;
      if (addr_ok) begin
        unique case (idx)
          IDX_ENABLE_PRIMARY:   s_d.rdata = {24'h000000, s_q.enable_primary};
          IDX_ENABLE_SECONDARY: s_d.rdata = {24'h000000, s_q.enable_secondary};
          IDX_STATUS_PRIMARY: begin
            s_d.rdata     = {24'h000000, s_q.status_primary};
            s_d.read_snap = s_q.status_primary;
          end
          IDX_STATUS_SECONDARY: begin
            s_d.rdata     = {24'h000000, s_q.status_secondary};
            s_d.read_snap = s_q.status_secondary;
          end
          IDX_FIFO_STATUS:      s_d.rdata = {24'h000000, fifo_status};
          IDX_RX_LENGTH_UPPER:  s_d.rdata = {24'h000000, s_q.rx_length_upper};
          default:              s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Writes take effect at the access edge; status registers ignore writes
    if (access && pwrite && addr_ok) begin
      unique case (idx)
        IDX_ENABLE_PRIMARY:   s_d.enable_primary   = pwdata[7:0];
        IDX_ENABLE_SECONDARY: s_d.enable_secondary = pwdata[7:0];
        IDX_RX_LENGTH_UPPER:  s_d.rx_length_upper  = pwdata[7:0];
        default:              s_d.rx_length_upper  = s_q.rx_length_upper;
      endcase
    end

    if (!chip_on) begin
      s_d.status_primary   = RST_STATUS;
      s_d.status_secondary = RST_STATUS;
      s_d.overflow         = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q.enable_primary   <= RST_ENABLE_PRIMARY;
      s_q.enable_secondary <= RST_ENABLE_SECONDARY;
      s_q.status_primary   <= RST_STATUS;
      s_q.status_secondary <= RST_STATUS;
      s_q.rx_length_upper  <= RST_RX_LENGTH_UPPER;
      s_q.overflow         <= 1'b0;
      s_q.fifo_cond        <= 1'b0;
      s_q.second_cond      <= 1'b0;
      s_q.chip_en_sync     <= 2'b00;
      s_q.ana_meta         <= 3'b000;
      s_q.ana_sync         <= 3'b000;
      s_q.ana_last         <= 3'b000;
      s_q.read_snap        <= 8'h00;
      s_q.rdata            <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // No wait states: data is ready in the access cycle
  assign pready  = access;
  assign pslverr = access && !addr_ok;
  assign prdata  = s_q.rdata;

  assign irq = |(s_q.status_primary & s_q.enable_primary & PRIMARY_USED) ||
               |(s_q.status_secondary & s_q.enable_secondary & SECONDARY_USED);

  assign abort_receive = events.no_response_timeout && s_q.enable_primary[P_NO_RESP] && fifo.rx_active;

  // Routing option for the receive path
  assign direct_fifo_second_byte_option = option;

endmodule : reader_irq_status

//--- bench/reader_irq_chk.sv
`timescale 1ns/1ps
module reader_irq_chk (
  // Clock and bus
  input wire logic                           clock,
  input wire logic                           sys_rst,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [11:0]                    paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic [31:0]                    prdata,
  // Pins and core
  input wire logic                           chip_enable,
  input wire logic                           irq,
  input wire logic                           abort_receive,
  input wire reader_irq_pkg::reader_events_t events,
  input wire reader_irq_pkg::fifo_view_t     fifo
);
  import reader_irq_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Shadow of the no-response enable, tracked from bus writes
  logic noresp_en_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      noresp_en_q <= RST_ENABLE_PRIMARY[P_NO_RESP];
    end else if (psel && penable && pwrite && paddr == 12'h0d4) begin
      noresp_en_q <= pwdata[P_NO_RESP];
    end
  end
  sequence s_rd(logic [11:0] a);
    psel && !penable && paddr == a;
  endsequence
  property p_fifo;
    s_rd(12'h0e4) |=> prdata[7] == $past(fifo.tx_active) && prdata[6] == $past(fifo.rx_active);
  endproperty
  property p_cnt;
    s_rd(12'h0e4) |=> prdata[4:0] == ($past(fifo.level) == 6'h0 ? 5'h1f : 5'($past(fifo.level)));
  endproperty
  property p_rsv1;
    s_rd(12'h0dc) |=> prdata[2] == 1'b0 && prdata[31:8] == 24'h0;
  endproperty
  property p_rsv2;
    s_rd(12'h0e0) |=> prdata[5:3] == 3'h0 && prdata[31:8] == 24'h0;
  endproperty
  // Sync delay covered by five low cycles
  property p_ce;
    (!chip_enable)[*5] ##0 (psel && !penable && (paddr == 12'h0dc || paddr == 12'h0e0)) |=> prdata[7:0] == 8'h0;
  endproperty
  property p_off;
    (!chip_enable)[*6] |-> !irq;
  endproperty
  property p_rst;
    $fell(sys_rst) |-> !irq && prdata == 32'h0;
  endproperty
  // Abort needs the enable as well as the timer
  property p_abort;
    abort_receive |-> noresp_en_q && events.no_response_timeout && fifo.rx_active;
  endproperty
  property p_abort_on;
    noresp_en_q && events.no_response_timeout && fifo.rx_active |-> abort_receive;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo activity bits wrong");
  a_cnt: assert property (p_cnt) else $error("fifo count wrong");
  a_rsv1: assert property (p_rsv1) else $error("primary reserved bit set");
  a_rsv2: assert property (p_rsv2) else $error("secondary reserved bits set");
  a_ce: assert property (p_ce) else $error("status not cleared by chip enable");
  a_off: assert property (p_off) else $error("irq high with chip disabled");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_abort: assert property (p_abort) else $error("abort without cause");
  a_abort_on: assert property (p_abort_on) else $error("enabled timeout did not abort");
endmodule : reader_irq_chk
bind reader_irq_status reader_irq_chk chk_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .chip_enable(chip_enable), .irq(irq),
  .abort_receive(abort_receive), .events(events), .fifo(fifo));

//--- bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic        clock,
  // APB master
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [11:0]     paddr,
  output logic [31:0]     pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // No wait count assumed; bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge clock) psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : host_model

//--- bench/reader_irq_and_fifo_status_tb_top.sv
`timescale 1ns/1ps
module reader_irq_and_fifo_status_tb_top;
  import reader_irq_pkg::*;
  logic clock, sys_rst, chip_enable, psel, penable, pwrite, pready, pslverr, irq, abort_receive, opt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] x;
  analog_status_t analog_pins;
  reader_events_t events;
  fifo_view_t fifo;
  int err_total, total_checks, seed;
  int lv[5] = '{0, 5, 6, 18, 19};
  reader_irq_status dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
    .analog_pins(analog_pins), .events(events), .fifo(fifo), .irq(irq), .abort_receive(abort_receive),
    .direct_fifo_second_byte_option(opt));
  host_model host_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
    logic [31:0] d;
    logic e;
    host_u.xfer(1'b0, idx, 8'h0, d, e);
    chk({e, d}, exp);
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic e;
    host_u.xfer(1'b1, idx, v, d, e);
    chk({32'h0, e}, 33'h0);
  endtask : wr
  task automatic pulse(input reader_events_t ev);
    @(posedge clock) events <= ev;
    @(posedge clock) events <= '0;
    #1;
  endtask : pulse
  function automatic logic [15:0] exp_of(input reader_events_t e);
    return {e.tx_done, e.rx_done, 1'b0, |{e.crc_error, e.length_error, e.protocol_error, e.preamble_error},
      e.header_bit_one, 1'b0, e.auto_ack_done, e.no_response_timeout, 1'b0, e.cmd_done, 3'h0, e.crc_error,
      e.length_error | e.protocol_error, e.preamble_error};
  endfunction : exp_of
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    chip_enable = 1'b1;
    analog_pins = '0;
    events = '0;
    fifo = '0;
    seed = 32'h0274;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(8'h35, RST_ENABLE_PRIMARY);
    rd(8'h36, RST_ENABLE_SECONDARY);
    rd(8'h37, 8'h0);
    rd(8'h39, 8'h1f);
    rd(8'h40, 33'h1_0000_0000);
    wr(8'h37, 8'hff);
    rd(8'h37, 8'h0);
    // Random events and enables, all-ones first
    @(posedge clock) fifo.rx_active <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      r = (i == 0) ? 32'hffff_ffff : $random(seed);
      wr(8'h35, r[7:0]);
      wr(8'h36, r[15:8]);
      pulse(r[25:16]);
      x = exp_of(r[25:16]);
      chk(33'(irq), 33'(|((x[15:8] & r[7:0]) | (x[7:0] & r[15:8]))));
      rd(8'h37, x[15:8]);
      rd(8'h38, x[7:0]);
      rd(8'h37, 8'h0);
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clock) fifo <= {i[0], !i[0], 1'b0, 6'(lv[i / 2])};
      repeat (2) @(posedge clock);
      rd(8'h37, ((i[0] && lv[i / 2] < 6) || (!i[0] && lv[i / 2] > 18)) ? 8'h20 : 8'h0);
      rd(8'h39, {i[0], !i[0], 1'b0, lv[i / 2] == 0 ? 5'h1f : 5'(lv[i / 2])});
      @(posedge clock) fifo <= '0;
    end
    // Overflow only past capacity
    for (int k = 23; k < 25; k++) begin
      @(posedge clock) fifo <= {3'b011, 6'(k)};
      @(posedge clock) fifo.push <= 1'b0;
      rd(8'h38, 33'(k == 24));
      rd(8'h39, {2'b01, k == 24, 5'(k)});
    end
    rd(8'h37, 8'h30);
    @(posedge clock) fifo <= '0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock) analog_pins <= analog_pins ^ (3'b001 << (i % 3));
      repeat (5) @(posedge clock);
      rd(8'h38, 8'h80);
    end
    pulse(10'h240);
    @(posedge clock) chip_enable <= 1'b0;
    repeat (6) @(posedge clock);
    rd(8'h37, 8'h0);
    rd(8'h38, 8'h0);
    @(posedge clock) chip_enable <= 1'b1;
    repeat (4) @(posedge clock);
    wr(8'h3a, 8'h40);
    // Option flop updates only after the access edge
    #1;
    chk(33'(opt), 33'h1);
    pulse(10'h080);
    rd(8'h37, 8'h0);
    @(posedge clock) fifo <= {3'b010, 6'd2};
    repeat (2) @(posedge clock);
    rd(8'h37, 8'h08);
    // Inventory style host: main error only, primary read frees the line
    wr(8'h36, 8'h00);
    wr(8'h35, 8'h10);
    pulse(10'h008);
    chk(33'(irq), 33'h1);
    rd(8'h37, 8'h10);
    #1;
    chk(33'(irq), 33'h0);
    rd(8'h38, 8'h04);
    tally_and_finish();
  end
endmodule : reader_irq_and_fifo_status_tb_top
